// *** cdc_params.svh ***
`ifndef CDC_PARAMS_SVH
`define CDC_PARAMS_SVH

`define CDC_POR_CYCLES 8'h10
`define CDC_INIT_CYCLES 8'h08
`define CDC_CNT_W 8

`endif

// *** cdc_pkg.sv ***
package cdc_pkg;
    typedef enum logic [5:0] {
        CDC_RESET   = 6'h01,
        CDC_WAIT_CE = 6'h02,
        CDC_LOAD    = 6'h04,
        CDC_INIT    = 6'h08,
        CDC_USER    = 6'h10,
        CDC_ERROR   = 6'h20
    } cdc_state_t;
endpackage

// *** cdc_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Two-stage synchroniser
// ****************************************
module cdc_sync (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic async_in,
    output logic sync_out
);
    logic meta_ff;
    logic sync_ff;
    logic nxt_meta;
    logic nxt_sync;

    always_comb begin
        nxt_meta = async_in;
        nxt_sync = meta_ff;
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            meta_ff <= 1'h1;
            sync_ff <= 1'h1;
        end else begin
            meta_ff <= nxt_meta;
            sync_ff <= nxt_sync;
        end
    end

    assign sync_out = sync_ff;
endmodule
`default_nettype wire

// *** cdc_config_done.sv ***
// Contract
// - Config-complete line driven low before and during configuration.
// - Line released only after all bits, no error, initialization started.
// - Enter user mode only after data received and line seen high.
// - After user mode, external low on the line is ignored.
// - Chain-enable output driven low when own configuration completes.
// - Memory select enables serial memory, or parallel flash enable.
// - Option off frees chain pin as user I/O after configuration.
// - Drive error line low on error; external low during load or initialization enters error state.
// - Reconfig request low resets, floats pins; high starts new configuration.
`timescale 1ns/1ps
`default_nettype none
`include "cdc_params.svh"
module cdc_config_done
    import cdc_pkg::*;
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic chip_enable_n_in,
    input wire logic reconfig_request_in,
    input wire logic config_complete_line_in,
    input wire logic error_status_in,
    input wire logic active_serial_scheme,
    input wire logic active_parallel_scheme,
    input wire logic chain_out_enable_opt,
    input wire logic data_all_received,
    input wire logic data_error,
    input wire logic user_chain_pin_out,
    input wire logic user_chain_pin_oe,
    output logic config_complete_line_out,
    output logic config_complete_line_oe,
    output logic chain_enable_out,
    output logic chain_enable_oe,
    output logic error_status_out,
    output logic error_status_oe,
    output logic serial_memory_select_n,
    output logic serial_memory_select_oe,
    output logic user_pins_float,
    output logic user_mode
);
    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic ce_n_s;
    logic reconfig_s;
    logic done_line_s;
    logic err_line_s;

    cdc_sync u_sync_ce (.clock(clock), .sys_rst(sys_rst),
        .async_in(chip_enable_n_in), .sync_out(ce_n_s));
    cdc_sync u_sync_rc (.clock(clock), .sys_rst(sys_rst),
        .async_in(reconfig_request_in), .sync_out(reconfig_s));
    cdc_sync u_sync_dn (.clock(clock), .sys_rst(sys_rst),
        .async_in(config_complete_line_in), .sync_out(done_line_s));
    cdc_sync u_sync_er (.clock(clock), .sys_rst(sys_rst),
        .async_in(error_status_in), .sync_out(err_line_s));

    // ****************************************
    // Configuration sequencer
    // ****************************************
    cdc_state_t state_ff;
    cdc_state_t nxt_state;
    logic [`CDC_CNT_W-1:0] cnt_ff;
    logic [`CDC_CNT_W-1:0] nxt_cnt;
    logic own_err_ff;
    logic nxt_own_err;

    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_own_err = own_err_ff;
        if (!reconfig_s) begin
            nxt_state = CDC_RESET;
            nxt_cnt = '0;
            nxt_own_err = 1'h0;
        end else begin
            unique case (state_ff)
                CDC_RESET: begin
                    if (cnt_ff == `CDC_POR_CYCLES) begin
                        nxt_state = CDC_WAIT_CE;
                        nxt_cnt = '0;
                    end else begin
                        nxt_cnt = cnt_ff + 1'h1;
                    end
                end
                CDC_WAIT_CE: begin
                    // Status line must read back released first, else its
                    // synchroniser lag would look like an external error
                    if (!ce_n_s && err_line_s) begin
                        nxt_state = CDC_LOAD;
                    end
                end
                CDC_LOAD: begin
                    if (!err_line_s) begin
                        nxt_state = CDC_ERROR;
                    end else if (data_error) begin
                        nxt_state = CDC_ERROR;
                        nxt_own_err = 1'h1;
                    end else if (ce_n_s) begin
                        nxt_state = CDC_WAIT_CE;
                    end else if (data_all_received) begin
                        nxt_state = CDC_INIT;
                        nxt_cnt = '0;
                    end
                end
                CDC_INIT: begin
                    if (!err_line_s) begin
                        nxt_state = CDC_ERROR;
                    end else if (done_line_s) begin
                        // Count only while the line is seen high
                        if (cnt_ff == `CDC_INIT_CYCLES) begin
                            nxt_state = CDC_USER;
                        end else begin
                            nxt_cnt = cnt_ff + 1'h1;
                        end
                    end
                end
                CDC_USER: begin
                    nxt_state = CDC_USER;
                end
                CDC_ERROR: begin
                    nxt_state = CDC_ERROR;
                end
                default: begin
                    nxt_state = CDC_RESET;
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state_ff <= CDC_RESET;
            cnt_ff <= '0;
            own_err_ff <= 1'h0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            own_err_ff <= nxt_own_err;
        end
    end

    // ****************************************
    // Pin drivers
    // ****************************************
    logic done_oe_ff, nxt_done_oe;
    logic chain_oe_ff, nxt_chain_oe;
    logic chain_out_ff, nxt_chain_out;
    logic err_oe_ff, nxt_err_oe;
    logic msel_n_ff, nxt_msel_n;
    logic msel_oe_ff, nxt_msel_oe;
    logic float_ff, nxt_float;
    logic user_ff, nxt_user;

    always_comb begin
        nxt_done_oe = (nxt_state != CDC_INIT) && (nxt_state != CDC_USER);
        nxt_user = (nxt_state == CDC_USER);
        nxt_chain_out = 1'h0;
        nxt_chain_oe = 1'h0;
        if (nxt_user) begin
            if (chain_out_enable_opt) begin
                nxt_chain_oe = 1'h1;
            end else begin
                nxt_chain_out = user_chain_pin_out;
                nxt_chain_oe = user_chain_pin_oe;
            end
        end
        nxt_err_oe = (nxt_state == CDC_RESET) ||
            ((nxt_state == CDC_ERROR) && nxt_own_err);
        nxt_msel_oe = (active_serial_scheme || active_parallel_scheme) &&
            (nxt_state != CDC_USER);
        nxt_msel_n = !(nxt_state == CDC_LOAD);
        nxt_float = !nxt_user;
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            done_oe_ff <= 1'h1;
            chain_oe_ff <= 1'h0;
            chain_out_ff <= 1'h0;
            err_oe_ff <= 1'h1;
            msel_n_ff <= 1'h1;
            msel_oe_ff <= 1'h0;
            float_ff <= 1'h1;
            user_ff <= 1'h0;
        end else begin
            done_oe_ff <= nxt_done_oe;
            chain_oe_ff <= nxt_chain_oe;
            chain_out_ff <= nxt_chain_out;
            err_oe_ff <= nxt_err_oe;
            msel_n_ff <= nxt_msel_n;
            msel_oe_ff <= nxt_msel_oe;
            float_ff <= nxt_float;
            user_ff <= nxt_user;
        end
    end

    assign config_complete_line_out = 1'h0;
    assign config_complete_line_oe = done_oe_ff;
    assign chain_enable_out = chain_out_ff;
    assign chain_enable_oe = chain_oe_ff;
    assign error_status_out = 1'h0;
    assign error_status_oe = err_oe_ff;
    assign serial_memory_select_n = msel_n_ff;
    assign serial_memory_select_oe = msel_oe_ff;
    assign user_pins_float = float_ff;
    assign user_mode = user_ff;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    done_low_load_a: assert property ((state_ff == CDC_LOAD) |-> config_complete_line_oe)
        else $error("done line released during load");
    done_release_a: assert property ($fell(config_complete_line_oe) |->
        $past(data_all_received) && !$past(data_error))
        else $error("done line released without data");
    user_needs_high_a: assert property ($rose(user_mode) |-> $past(done_line_s))
        else $error("user mode without done high");
    user_stays_a: assert property ((user_mode && reconfig_s) |=> user_mode)
        else $error("user mode lost");
    ce_gate_a: assert property ((state_ff == CDC_WAIT_CE && ce_n_s) |=> state_ff != CDC_LOAD)
        else $error("load without chip enable");
    chain_drive_a: assert property ((user_mode && chain_out_enable_opt) |-> chain_enable_oe)
        else $error("chain not driven");
    chain_released_a: assert property (!user_mode |-> !chain_enable_oe)
        else $error("chain driven early");
    msel_load_a: assert property ((state_ff == CDC_LOAD) |->
        !serial_memory_select_n)
        else $error("memory not selected");
    chain_user_a: assert property ((user_mode && !chain_out_enable_opt) |->
        chain_enable_oe == $past(user_chain_pin_oe))
        else $error("user pin not passed");
    err_enter_a: assert property ((state_ff == CDC_LOAD && !err_line_s && reconfig_s) |=>
        state_ff == CDC_ERROR)
        else $error("external error ignored");
    reconfig_a: assert property (!reconfig_s |=> state_ff == CDC_RESET ##1 user_pins_float)
        else $error("reconfig not honoured");

    user_c: cover property ($rose(user_mode));
    error_c: cover property (state_ff == CDC_ERROR);
    reconf_c: cover property (user_mode ##1 !reconfig_s);
endmodule
`default_nettype wire

// *** cdc_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Board pull-ups and next device in chain
// ****************************************
module cdc_host_model (
    input wire logic done_oe,
    input wire logic err_oe,
    input wire logic chain_oe,
    input wire logic chain_out,
    input wire logic pull_done_low,
    input wire logic pull_err_low,
    output logic done_line,
    output logic err_line,
    output logic next_ce_n
);
    // Released open-drain lines float up to the pull-up level
    assign done_line = ~(done_oe | pull_done_low);
    assign err_line = ~(err_oe | pull_err_low);
    assign next_ce_n = chain_oe ? chain_out : 1'h1;
endmodule
`default_nettype wire

// *** test_config_done_chain_select.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_config_done_chain_select;
    logic clock = 1'h0;
    logic sys_rst = 1'h1;
    logic ce_n = 1'h0;
    logic rcfg = 1'h1;
    logic opt = 1'h1;
    logic dar = 1'h0;
    logic derr = 1'h0;
    logic upo = 1'h1;
    logic upoe = 1'h1;
    logic as_s = 1'h1;
    logic ap_s = 1'h0;
    logic f_done = 1'h0;
    logic f_err = 1'h0;
    logic done_line, err_line, next_ce_n, done_out, done_oe, ch_out, ch_oe;
    logic err_out, err_oe, msel_n, msel_oe, flt, umode;
    int bad_count = 0;
    int check_count = 0;
    cdc_host_model partner (.done_oe(done_oe), .err_oe(err_oe), .chain_oe(ch_oe),
        .chain_out(ch_out), .pull_done_low(f_done), .pull_err_low(f_err),
        .done_line(done_line), .err_line(err_line), .next_ce_n(next_ce_n));
    cdc_config_done DUT (.clock(clock), .sys_rst(sys_rst), .chip_enable_n_in(ce_n),
        .reconfig_request_in(rcfg), .config_complete_line_in(done_line),
        .error_status_in(err_line), .active_serial_scheme(as_s),
        .active_parallel_scheme(ap_s), .chain_out_enable_opt(opt),
        .data_all_received(dar), .data_error(derr), .user_chain_pin_out(upo),
        .user_chain_pin_oe(upoe), .config_complete_line_out(done_out),
        .config_complete_line_oe(done_oe), .chain_enable_out(ch_out),
        .chain_enable_oe(ch_oe), .error_status_out(err_out), .error_status_oe(err_oe),
        .serial_memory_select_n(msel_n), .serial_memory_select_oe(msel_oe),
        .user_pins_float(flt), .user_mode(umode));
    initial begin
        forever #20 clock = ~clock;
    end
    task automatic chk(input string what, input logic exp, input logic got);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clock);
    endtask
    // Waits until the memory is selected, i.e. loading has begun
    task automatic wait_load();
        for (int i = 0; i < 60 && msel_n !== 1'h0; i++) cyc(1);
        chk("memory_select", 1'h0, msel_n);
        chk("memory_oe_load", 1'h1, msel_oe);
    endtask
    task automatic pulse_dar();
        dar = 1'h1;
        cyc(1);
        dar = 1'h0;
    endtask
    task automatic wait_user();
        for (int i = 0; i < 40 && umode !== 1'h1; i++) cyc(1);
        chk("user_mode", 1'h1, umode);
        chk("pins_float", 1'h0, flt);
        chk("memory_oe_user", 1'h0, msel_oe);
    endtask
    task automatic t_first_config();
        chk("done_oe_por", 1'h1, done_oe);
        chk("done_drive_low", 1'h0, done_out);
        chk("chain_oe_por", 1'h0, ch_oe);
        wait_load();
        chk("done_oe_load", 1'h1, done_oe);
        chk("next_ce_load", 1'h1, next_ce_n);
        f_done = 1'h1;
        pulse_dar();
        cyc(1);
        chk("done_oe_rel", 1'h0, done_oe);
        cyc(20);
        chk("user_held", 1'h0, umode);
        f_done = 1'h0;
        wait_user();
        chk("chain_oe", 1'h1, ch_oe);
        chk("next_ce", 1'h0, next_ce_n);
    endtask
    task automatic t_user_ignores();
        f_done = 1'h1;
        f_err = 1'h1;
        cyc(10);
        chk("user_kept", 1'h1, umode);
        chk("err_oe_user", 1'h0, err_oe);
        f_done = 1'h0;
        f_err = 1'h0;
    endtask
    task automatic t_reconfig();
        rcfg = 1'h0;
        cyc(5);
        chk("user_off", 1'h0, umode);
        chk("float_on", 1'h1, flt);
        chk("chain_rel", 1'h0, ch_oe);
        rcfg = 1'h1;
        wait_load();
    endtask
    task automatic t_errors();
        ce_n = 1'h1;
        cyc(6);
        chk("ce_high_desel", 1'h1, msel_n);
        ce_n = 1'h0;
        wait_load();
        derr = 1'h1;
        cyc(1);
        derr = 1'h0;
        cyc(1);
        chk("err_own", 1'h1, err_oe);
        chk("err_drive_low", 1'h0, err_out);
        pulse_dar();
        cyc(30);
        chk("err_no_user", 1'h0, umode);
        t_reconfig();
        f_err = 1'h1;
        cyc(5);
        f_err = 1'h0;
        pulse_dar();
        cyc(30);
        chk("ext_err_no_user", 1'h0, umode);
    endtask
    task automatic t_option_off();
        opt = 1'h0;
        // Parallel scheme: same select pin acts as flash enable
        as_s = 1'h0;
        ap_s = 1'h1;
        t_reconfig();
        pulse_dar();
        wait_user();
        upo = 1'h0;
        cyc(4);
        chk("chain_user_oe", 1'h1, ch_oe);
        chk("chain_user_out", 1'h0, ch_out);
        upoe = 1'h0;
        cyc(4);
        chk("chain_user_off", 1'h0, ch_oe);
    endtask
    initial begin
        cyc(5);
        sys_rst = 1'h0;
        t_first_config();
        t_user_ignores();
        t_reconfig();
        t_errors();
        t_option_off();
        tally_and_finish();
    end
    // Whole run needs well under 2000 cycles
    initial begin
        repeat (5000) @(posedge clock);
        bad_count++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
